// ---- hdl/pvl_regs.svh ----
/*
 Register offsets, field positions, reset values and band constants of the
 voltage-loop filter select block.
 Assumes inclusion by bare name from pvl_top, the only file that includes it.
*/
`ifndef PVL_REGS_SVH
`define PVL_REGS_SVH

// Register indexes, byte address is four times the index
`define PVL_IDX_VLOOP_GAIN 16'hfe20
`define PVL_IDX_VLOOP_ZERO 16'hfe21
`define PVL_IDX_FAST_GAIN 16'hfe22
`define PVL_IDX_FAST_ZERO 16'hfe23
`define PVL_IDX_FAST_CTRL 16'hfe24
`define PVL_IDX_STATUS 16'hfe3f

// Control register fields
`define PVL_CTL_LINE_TRANS 7
`define PVL_CTL_BAND_HI 6
`define PVL_CTL_BAND_LO 5
`define PVL_CTL_DELAY_HI 4
`define PVL_CTL_DELAY_LO 2
`define PVL_CTL_SOFT_START 1
`define PVL_CTL_DELAYED 0

// Reset values
`define PVL_RST_VLOOP_GAIN 8'h00
`define PVL_RST_VLOOP_ZERO 8'h00
`define PVL_RST_FAST_GAIN 8'h00
`define PVL_RST_FAST_ZERO 8'h00
`define PVL_RST_FAST_CTRL 8'h00

// Band limits in units of 1/6400 of the reference
`define PVL_BAND_SCALE 13'h1900
`define PVL_BAND_0 10'h064
`define PVL_BAND_1 10'h0c8
`define PVL_BAND_2 10'h190
`define PVL_BAND_3 10'h320
`define PVL_BAND_EXTRA 10'h0c0

`endif

// ---- hdl/pvl_pkg.sv ----
/*
 Types of the voltage-loop filter select block.
 Assumes the register header sits beside it.
*/
`default_nettype none

package pvl_pkg;

    typedef enum logic [1:0] {
        PVL_NORMAL = 2'b00,
        PVL_FAST = 2'b01,
        PVL_HOLD = 2'b10
    } pvl_mode_type;

endpackage : pvl_pkg

`default_nettype wire

// ---- hdl/pvl_comp_filter.sv ----
/*
 Compensation filter datapath: one gain and one zero per sample,
 saturating 16-bit signed accumulator output.
 Assumes coefficients are held stable by the caller for each sample.
*/
`default_nettype none

module pvl_comp_filter
    import pvl_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Sample in
    input wire logic sample_i,
    input wire logic signed [12:0] err_i,
    input wire logic [7:0] gain_i,
    input wire logic [7:0] zero_i,
    // Result out
    output logic signed [15:0] out_o,
    output logic valid_o
);

    logic signed [12:0] prev_reg;
    logic signed [22:0] diff;
    logic signed [31:0] prod;
    logic signed [24:0] sum;
    logic signed [15:0] sat;

    always_comb begin
        diff = 23'(err_i * 14'sh100) - 23'(prev_reg * $signed({1'b0, zero_i}));
        prod = 32'(diff * $signed({1'b0, gain_i}));
        sum = 25'(out_o) + 25'(prod >>> 8);
        if (sum > 25'sh7fff) begin
            sat = 16'sh7fff;
        end else if (sum < -25'sh8000) begin
            sat = -16'sh8000;
        end else begin
            sat = sum[15:0];
        end
    end

    // Accumulator and previous error
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_reg <= 13'sh0;
            out_o <= 16'sh0;
        end else if (sample_i) begin
            prev_reg <= err_i;
            out_o <= sat;
        end
    end

    // Result strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            valid_o <= 1'b0;
        end else begin
            valid_o <= sample_i;
        end
    end

endmodule // pvl_comp_filter

`default_nettype wire

// ---- hdl/pvl_top.sv ----
/*
 Voltage-loop filter select: coefficient registers on a Wishbone slave,
 normal/fast mode selection and the compensation filter.
 Assumes sample, half-line-cycle and soft-start inputs synchronous to clk_i.
*/
`default_nettype none
`include "pvl_regs.svh"

// Function
// - Normal filter gain from 8-bit register
// - Normal filter zero from 8-bit register
// - Fast filter gain used in fast, hold and soft-start fast
// - Fast filter zero from 8-bit register
// - Bit 7 enters fast beyond band+3%
// - Bits 6:5 pick band 1.5625 to 12.5%
// - Return after bits 4:2 half cycles
// - Bit 0 enables delayed fast on band
module pvl_top
    import pvl_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [17:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Voltage sense
    input wire logic sample_valid_i,
    input wire logic [11:0] vout_i,
    input wire logic [11:0] vref_i,
    // Line and sequencing
    input wire logic half_cycle_i,
    input wire logic soft_start_i,
    // Loop output
    output logic signed [15:0] loop_out_o,
    output logic loop_valid_o,
    output logic fast_active_o
);

    logic [7:0] vloop_gain_reg;
    logic [7:0] vloop_zero_reg;
    logic [7:0] fast_gain_reg;
    logic [7:0] fast_zero_reg;
    logic [7:0] fast_ctrl_reg;
    logic ack_next;
    logic [15:0] idx;
    logic wr_en;
    logic [31:0] rd_data;
    pvl_mode_type mode_reg;
    pvl_mode_type mode_next;
    logic [2:0] hold_cnt_reg;
    logic [2:0] hold_cnt_next;
    logic signed [12:0] err;
    logic [11:0] abs_err;
    logic [24:0] err_mag;
    logic [9:0] band_units;
    logic [24:0] band_thr;
    logic [24:0] trans_thr;
    logic out_band;
    logic out_trans;
    logic ss_fast;
    logic ss_normal;
    logic use_fast;
    logic [7:0] act_gain_reg;
    logic [7:0] act_zero_reg;
    logic signed [12:0] err_reg;
    logic filt_go_reg;

    // Bus decode
    assign idx = wb_adr_i[17:2];
    assign ack_next = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];

    always_comb begin
        rd_data = 32'h0;
        if (idx == `PVL_IDX_VLOOP_GAIN) begin
            rd_data[7:0] = vloop_gain_reg;
        end else if (idx == `PVL_IDX_VLOOP_ZERO) begin
            rd_data[7:0] = vloop_zero_reg;
        end else if (idx == `PVL_IDX_FAST_GAIN) begin
            rd_data[7:0] = fast_gain_reg;
        end else if (idx == `PVL_IDX_FAST_ZERO) begin
            rd_data[7:0] = fast_zero_reg;
        end else if (idx == `PVL_IDX_FAST_CTRL) begin
            rd_data[7:0] = fast_ctrl_reg;
        end else if (idx == `PVL_IDX_STATUS) begin
            rd_data[5:0] = {hold_cnt_reg, use_fast, mode_reg};
        end
    end

    // Acknowledge, one wait state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= ack_next;
        end
    end

    // Read data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0;
        end else if (ack_next) begin
            wb_dat_o <= rd_data;
        end
    end

    // Coefficient and control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vloop_gain_reg <= `PVL_RST_VLOOP_GAIN;
            vloop_zero_reg <= `PVL_RST_VLOOP_ZERO;
            fast_gain_reg <= `PVL_RST_FAST_GAIN;
            fast_zero_reg <= `PVL_RST_FAST_ZERO;
            fast_ctrl_reg <= `PVL_RST_FAST_CTRL;
        end else if (wr_en) begin
            if (idx == `PVL_IDX_VLOOP_GAIN) begin
                vloop_gain_reg <= wb_dat_i[7:0];
            end else if (idx == `PVL_IDX_VLOOP_ZERO) begin
                vloop_zero_reg <= wb_dat_i[7:0];
            end else if (idx == `PVL_IDX_FAST_GAIN) begin
                fast_gain_reg <= wb_dat_i[7:0];
            end else if (idx == `PVL_IDX_FAST_ZERO) begin
                fast_zero_reg <= wb_dat_i[7:0];
            end else if (idx == `PVL_IDX_FAST_CTRL) begin
                fast_ctrl_reg <= wb_dat_i[7:0];
            end
        end
    end

    // Deviation against reference, scaled by 6400
    always_comb begin
        err = 13'({1'b0, vref_i}) - 13'({1'b0, vout_i});
        abs_err = err[12] ? 12'(-err) : err[11:0];
        err_mag = 25'(abs_err * `PVL_BAND_SCALE);
    end

    // Band threshold select
    always_comb begin
        case (fast_ctrl_reg[`PVL_CTL_BAND_HI:`PVL_CTL_BAND_LO])
            2'b00: band_units = `PVL_BAND_0;
            2'b01: band_units = `PVL_BAND_1;
            2'b10: band_units = `PVL_BAND_2;
            default: band_units = `PVL_BAND_3;
        endcase
        band_thr = 25'(vref_i * band_units);
        trans_thr = 25'(vref_i * 10'(band_units + `PVL_BAND_EXTRA));
        out_band = err_mag > band_thr;
        out_trans = err_mag > trans_thr;
    end

    // Soft start handling
    assign ss_fast = soft_start_i & fast_ctrl_reg[`PVL_CTL_SOFT_START];
    assign ss_normal = soft_start_i & ~fast_ctrl_reg[`PVL_CTL_SOFT_START];

    // Mode selection
    always_comb begin
        mode_next = mode_reg;
        hold_cnt_next = hold_cnt_reg;
        case (mode_reg)
            PVL_NORMAL: begin
                if (sample_valid_i && !ss_normal) begin
                    if (fast_ctrl_reg[`PVL_CTL_LINE_TRANS] && out_trans) begin
                        mode_next = PVL_FAST;
                    end else if (fast_ctrl_reg[`PVL_CTL_DELAYED] && out_band) begin
                        mode_next = PVL_FAST;
                    end
                end
            end
            PVL_FAST: begin
                if (ss_normal) begin
                    mode_next = PVL_NORMAL;
                end else if (sample_valid_i && !out_band) begin
                    hold_cnt_next = fast_ctrl_reg[`PVL_CTL_DELAY_HI:`PVL_CTL_DELAY_LO];
                    if (fast_ctrl_reg[`PVL_CTL_DELAY_HI:`PVL_CTL_DELAY_LO] == 3'h0) begin
                        mode_next = PVL_NORMAL;
                    end else begin
                        mode_next = PVL_HOLD;
                    end
                end
            end
            PVL_HOLD: begin
                if (ss_normal) begin
                    mode_next = PVL_NORMAL;
                end else if (sample_valid_i && out_band) begin
                    mode_next = PVL_FAST;
                end else if (half_cycle_i) begin
                    hold_cnt_next = hold_cnt_reg - 3'h1;
                    if (hold_cnt_reg == 3'h1) begin
                        mode_next = PVL_NORMAL;
                    end
                end
            end
            default: begin
                mode_next = PVL_NORMAL;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_reg <= PVL_NORMAL;
            hold_cnt_reg <= 3'h0;
        end else begin
            mode_reg <= mode_next;
            hold_cnt_reg <= hold_cnt_next;
        end
    end

    assign use_fast = ((mode_reg != PVL_NORMAL) & ~ss_normal) | ss_fast;

    // Coefficient set and error captured together at the sample
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            act_gain_reg <= 8'h00;
            act_zero_reg <= 8'h00;
            err_reg <= 13'sh0;
            filt_go_reg <= 1'b0;
        end else begin
            filt_go_reg <= sample_valid_i;
            if (sample_valid_i) begin
                err_reg <= err;
                act_gain_reg <= use_fast ? fast_gain_reg : vloop_gain_reg;
                act_zero_reg <= use_fast ? fast_zero_reg : vloop_zero_reg;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fast_active_o <= 1'b0;
        end else if (sample_valid_i) begin
            fast_active_o <= use_fast;
        end
    end

    pvl_comp_filter u_filter (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sample_i(filt_go_reg),
        .err_i(err_reg),
        .gain_i(act_gain_reg),
        .zero_i(act_zero_reg),
        .out_o(loop_out_o),
        .valid_o(loop_valid_o)
    );

endmodule // pvl_top

`default_nettype wire

// ---- dv/pvl_top_monitor.sv ----
/*
 Checker bound to the voltage-loop filter select top.
 Assumes the one-wait-state bus and the two-cycle sample path.
*/
`default_nettype none
module pvl_top_monitor (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [17:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Sense and loop state
    input wire logic sample_valid_i,
    input wire logic soft_start_i,
    input wire logic loop_valid_o,
    input wire logic fast_active_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] ctl_reg;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_reg <= 8'h00;
        end else if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[17:2] == 16'hfe24) begin
            ctl_reg <= wb_dat_i[7:0];
        end
    end
    chk_ack_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    chk_rd_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("upper read bits set");
    chk_ctl_read: assert property (wb_ack_o && !wb_we_i && wb_adr_i[17:2] == 16'hfe24
        |-> wb_dat_o[7:0] == ctl_reg) else $error("control readback wrong");
    chk_valid_lat: assert property (sample_valid_i |-> ##2 loop_valid_o)
        else $error("result missing");
    chk_valid_cause: assert property (loop_valid_o |-> $past(sample_valid_i, 2))
        else $error("result without sample");
    chk_mode_sample: assert property ($changed(fast_active_o) |-> $past(sample_valid_i))
        else $error("mode moved off sample");
    chk_ss_fast: assert property (sample_valid_i && soft_start_i && ctl_reg[1] |=> fast_active_o)
        else $error("soft start not fast");
    chk_ss_norm: assert property (sample_valid_i && soft_start_i && !ctl_reg[1] |=> !fast_active_o)
        else $error("soft start not normal");
    chk_no_entry: assert property (sample_valid_i && !fast_active_o && !soft_start_i
        && ctl_reg[7] == 1'b0 && ctl_reg[0] == 1'b0 |=> !fast_active_o) else $error("fast while off");
    cover property (sample_valid_i && fast_active_o);
    cover property ($fell(fast_active_o));
    cover property (wb_ack_o && wb_we_i);
endmodule // pvl_top_monitor
bind pvl_top pvl_top_monitor mon_u (.*);
`default_nettype wire

// ---- dv/pvl_sense_model.sv ----
/*
 Sense model: ADC sample every 8 clocks, half line cycle every 64.
 Assumes the bench sets the level and shares the clock.
*/
`default_nettype none
module pvl_sense_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Level set by the bench
    input wire logic [11:0] level_i,
    // To the block
    output logic sample_o,
    output logic [11:0] vout_o,
    output logic half_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] cnt_reg;
    always_ff @(posedge clk_i) begin
        cnt_reg <= rst_i ? 6'h00 : cnt_reg + 6'h01;
        sample_o <= !rst_i && cnt_reg[2:0] == 3'h7;
        half_o <= !rst_i && cnt_reg == 6'h3b;
        if (cnt_reg[2:0] == 3'h7) begin
            vout_o <= level_i;
        end
    end
endmodule // pvl_sense_model
`default_nettype wire

// ---- dv/testbench.sv ----
/*
 Bench: register access, mode switching and filter step checks.
 Assumes the sense model supplies samples and half line cycles.
*/
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [11:0] VREF = 12'hc80;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic soft_start_i = 1'b0;
    logic [17:0] wb_adr_i = 18'h00000;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [11:0] vref_i = 12'hc80;
    logic [11:0] vset = 12'hc80;
    logic [11:0] vout_i;
    logic [31:0] wb_dat_o;
    logic signed [15:0] loop_out_o;
    logic wb_ack_o, sample_valid_i, half_cycle_i, loop_valid_o, fast_active_o;
    logic [7:0] q;
    int bad_count = 0;
    int cmp_count = 0;
    int hc;
    pvl_top dut_u (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .sample_valid_i(sample_valid_i),
        .vout_i(vout_i),
        .vref_i(vref_i),
        .half_cycle_i(half_cycle_i),
        .soft_start_i(soft_start_i),
        .loop_out_o(loop_out_o),
        .loop_valid_o(loop_valid_o),
        .fast_active_o(fast_active_o)
    );
    pvl_sense_model sense_u (.clk_i, .rst_i, .level_i(vset), .sample_o(sample_valid_i),
        .vout_o(vout_i), .half_o(half_cycle_i));
    always #25 clk_i = ~clk_i;
    task automatic test_done();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] d, input logic s0);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h000000, d};
        wb_sel_i <= {3'h0, s0};
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rd_chk(input logic [15:0] idx, input logic [7:0] e);
        wb(1'b0, idx, 8'h00, 1'b1);
        check({8'h00, q}, {8'h00, e});
    endtask
    task automatic at(input logic [11:0] v, input logic f);
        @(posedge clk_i);
        vset <= v;
        repeat (4) @(posedge clk_i iff loop_valid_o === 1'b1);
        check({15'h0000, fast_active_o}, {15'h0000, f});
    endtask
    task automatic step_chk(input logic [15:0] e);
        logic signed [15:0] y0;
        @(posedge clk_i iff loop_valid_o === 1'b1);
        y0 = loop_out_o;
        @(posedge clk_i iff loop_valid_o === 1'b1);
        check(loop_out_o - y0, e);
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 5; i++) rd_chk(16'(16'hfe20 + i), 8'h00);
        for (int i = 0; i < 5; i++) begin
            wb(1'b1, 16'(16'hfe20 + i), 8'(8'h11 * (i + 1)), 1'b1);
            rd_chk(16'(16'hfe20 + i), 8'(8'h11 * (i + 1)));
        end
        wb(1'b1, 16'hfe20, 8'h00, 1'b0);
        rd_chk(16'hfe20, 8'h11);
        wb(1'b1, 16'hfe25, 8'hff, 1'b1);
        rd_chk(16'hfe25, 8'h00);
        wb(1'b1, 16'hfe20, 8'h04, 1'b1);
        wb(1'b1, 16'hfe21, 8'hc0, 1'b1);
        wb(1'b1, 16'hfe22, 8'h02, 1'b1);
        wb(1'b1, 16'hfe23, 8'h40, 1'b1);
        wb(1'b1, 16'hfe24, 8'h00, 1'b1);
        at(VREF - 12'h010, 1'b0);
        step_chk(16'h0010);
        @(posedge clk_i);
        soft_start_i <= 1'b1;
        wb(1'b1, 16'hfe24, 8'h02, 1'b1);
        at(VREF - 12'h010, 1'b1);
        step_chk(16'h0018);
        wb(1'b1, 16'hfe24, 8'h01, 1'b1);
        at(VREF - 12'h1f4, 1'b0);
        @(posedge clk_i);
        soft_start_i <= 1'b0;
        at(VREF - 12'h1f4, 1'b1);
        for (int b = 0; b < 4; b++) begin
            wb(1'b1, 16'hfe24, {1'b0, 2'(b), 5'h01}, 1'b1);
            at(VREF - (12'h032 << b) + 12'h002, 1'b0);
            at(VREF - (12'h032 << b) - 12'h002, 1'b1);
            at(VREF, 1'b0);
        end
        wb(1'b1, 16'hfe24, 8'h80, 1'b1);
        at(VREF - 12'h090, 1'b0);
        at(VREF - 12'h094, 1'b1);
        wb(1'b1, 16'hfe24, 8'h0d, 1'b1);
        at(VREF - 12'h064, 1'b1);
        rd_chk(16'hfe3f, 8'h05);
        @(posedge clk_i iff half_cycle_i);
        vset <= VREF;
        hc = 0;
        for (int k = 0; k < 600 && fast_active_o === 1'b1; k++) begin
            @(posedge clk_i);
            hc += int'(half_cycle_i);
        end
        check(16'(hc), 16'h0003);
        test_done();
    end
    initial begin
        #1000000;
        bad_count++;
        test_done();
    end
endmodule // testbench
`default_nettype wire
